// ---- common/timer3_defs.vh ----
`ifndef TIMER3_DEFS_VH
`define TIMER3_DEFS_VH

// register byte addresses
`define T3_ADDR_CTRL 12'h000
`define T3_ADDR_CTRL_CLR 12'h008
`define T3_ADDR_COUNT 12'h010
`define T3_ADDR_FIXED 12'h020
`define T3_ADDR_W 12

// control field positions
`define T3_SEL_HI 19
`define T3_SEL_LO 16
`define T3_IRQ_BIT 15
`define T3_IRQEN_BIT 14
`define T3_VALID_BIT 10
`define T3_DUTY_BIT 9
`define T3_POL_BIT 8
`define T3_UPD_BIT 7
`define T3_RELOAD_BIT 6

// source select codes
`define T3_SRC_NEVER 4'h0
`define T3_SRC_PWM0 4'h1
`define T3_SRC_PWM1 4'h2
`define T3_SRC_PWM2 4'h3
`define T3_SRC_PWM3 4'h4
`define T3_SRC_PWM4 4'h5
`define T3_SRC_QA 4'h6
`define T3_SRC_QB 4'h7
`define T3_SRC_XTAL 4'h8
`define T3_SRC_ALWAYS 4'hC

// widths and reset values
`define T3_CNT_W 16
`define T3_CNT_ZERO 16'h0000
`define T3_CNT_ONE 16'h0001
`define T3_NSRC 8
`define T3_WORD_ZERO 32'h0000_0000
`define T3_SEL_RST 4'h0

`endif

// ---- hdl/pin_sync.v ----
`timescale 1ns/100ps
module pin_sync
(
   input wire core_clk,
   input wire nrst,
   input wire ce,
   input wire [7:0] pins,
   output reg [7:0] level_q
);
   reg [7:0] s1_q;
   reg [7:0] s2_q;
   reg [7:0] s3_q;
   integer i;

   // three-stage chain; a bit changes only once stages two and three agree
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
         s3_q <= 8'h00;
         level_q <= 8'h00;
      end
      else if (ce)
      begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (i = 0; i < 8; i = i + 1)
         begin
            if (s2_q[i] == s3_q[i])
               level_q[i] <= s3_q[i];
         end
      end
   end
endmodule

// ---- hdl/timer3_ctrl.v ----
`timescale 1ns/100ps
`include "timer3_defs.vh"
module timer3_ctrl
(
   input wire core_clk,
   input wire nrst,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [4:0] pulse_in,
   input wire quadrature_input_a,
   input wire quadrature_input_b,
   input wire xtal_32k,
   output wire timer_irq
);
   reg [3:0] sel_q;
   reg irq_flag_q;
   reg irq_en_q;
   reg valid_q;
   reg duty_q;
   reg pol_q;
   reg upd_q;
   reg reload_q;
   reg [`T3_CNT_W-1:0] fixed_q;
   reg [`T3_CNT_W-1:0] count_q;
   reg [`T3_CNT_W-1:0] hi_cnt_q;
   reg [`T3_CNT_W-1:0] lo_cnt_q;
   reg [`T3_CNT_W-1:0] res_hi_q;
   reg [`T3_CNT_W-1:0] res_lo_q;
   reg armed_q;
   reg prev_q;
   wire [7:0] src_level;
   reg raw_level;
   wire level;
   wire edge_det;
   wire tick;
   wire setup;
   wire acc;
   wire wr;
   wire [`T3_ADDR_W-1:0] addr;
   wire mapped;
   wire wr_ctrl;
   wire wr_clr;
   wire wr_fixed;
   wire [`T3_CNT_W-1:0] cnt_dec;
   wire zero_hit;

   // all external sources cross into core_clk through one synchroniser bank
   pin_sync u_sync
   (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .pins({xtal_32k, quadrature_input_b, quadrature_input_a, pulse_in}),
      .level_q(src_level)
   );

   // source multiplexer; unlisted codes other than always-tick (4'hC) behave as never-tick
   always @*
   begin
      case (sel_q)
         `T3_SRC_PWM0: raw_level = src_level[0];
         `T3_SRC_PWM1: raw_level = src_level[1];
         `T3_SRC_PWM2: raw_level = src_level[2];
         `T3_SRC_PWM3: raw_level = src_level[3];
         `T3_SRC_PWM4: raw_level = src_level[4];
         `T3_SRC_QA: raw_level = src_level[5];
         `T3_SRC_QB: raw_level = src_level[6];
         `T3_SRC_XTAL: raw_level = src_level[7];
         default: raw_level = 1'b0;
      endcase
   end

   // polarity inversion sits ahead of the edge detector
   assign level = raw_level ^ pol_q;
   assign edge_det = level & ~prev_q;
   // always-tick bypasses the edge detector, never-tick yields no edge at all
   assign tick = (sel_q == `T3_SRC_ALWAYS) | edge_det;

   // apb decode; zero wait states, unmapped addresses raise pslverr
   assign setup = psel & ~penable;
   assign acc = psel & penable;
   assign addr = paddr[`T3_ADDR_W-1:0];
   assign mapped = (addr == `T3_ADDR_CTRL) | (addr == `T3_ADDR_CTRL_CLR) |
                   (addr == `T3_ADDR_COUNT) | (addr == `T3_ADDR_FIXED);
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;
   assign wr = acc & pwrite;
   assign wr_ctrl = wr & (addr == `T3_ADDR_CTRL);
   assign wr_clr = wr & (addr == `T3_ADDR_CTRL_CLR);
   assign wr_fixed = wr & (addr == `T3_ADDR_FIXED);

   assign cnt_dec = count_q - `T3_CNT_ONE;
   assign zero_hit = ~duty_q & tick & (count_q == `T3_CNT_ONE);

   // interrupt only in normal counter mode
   assign timer_irq = irq_flag_q & irq_en_q & ~duty_q;

   // read data is captured in the setup cycle so it is a flop in the access cycle
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         prdata <= `T3_WORD_ZERO;
      else if (ce & setup)
      begin
         prdata <= `T3_WORD_ZERO; // reserved bits read zero
         case (addr)
            `T3_ADDR_CTRL, `T3_ADDR_CTRL_CLR:
            begin
               prdata[`T3_SEL_HI:`T3_SEL_LO] <= sel_q;
               prdata[`T3_IRQ_BIT] <= irq_flag_q;
               prdata[`T3_IRQEN_BIT] <= irq_en_q;
               prdata[`T3_VALID_BIT] <= valid_q;
               prdata[`T3_DUTY_BIT] <= duty_q;
               prdata[`T3_POL_BIT] <= pol_q;
               prdata[`T3_UPD_BIT] <= upd_q;
               prdata[`T3_RELOAD_BIT] <= reload_q;
            end
            // in duty mode the count word holds low time above high time
            `T3_ADDR_COUNT:
               prdata <= duty_q ? {res_lo_q, res_hi_q} : {`T3_CNT_ZERO, count_q};
            `T3_ADDR_FIXED:
               prdata <= {`T3_CNT_ZERO, fixed_q};
            default:
               prdata <= `T3_WORD_ZERO;
         endcase
      end
   end

   // control fields; the clear alias clears every writable bit that is set in pwdata
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sel_q <= `T3_SEL_RST;
         irq_en_q <= 1'b0;
         duty_q <= 1'b0;
         pol_q <= 1'b0;
         upd_q <= 1'b0;
         reload_q <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_ctrl)
         begin
            sel_q <= pwdata[`T3_SEL_HI:`T3_SEL_LO];
            irq_en_q <= pwdata[`T3_IRQEN_BIT];
            duty_q <= pwdata[`T3_DUTY_BIT];
            pol_q <= pwdata[`T3_POL_BIT];
            upd_q <= pwdata[`T3_UPD_BIT];
            reload_q <= pwdata[`T3_RELOAD_BIT];
         end
         else if (wr_clr)
         begin
            sel_q <= sel_q & ~pwdata[`T3_SEL_HI:`T3_SEL_LO];
            irq_en_q <= irq_en_q & ~pwdata[`T3_IRQEN_BIT];
            duty_q <= duty_q & ~pwdata[`T3_DUTY_BIT];
            pol_q <= pol_q & ~pwdata[`T3_POL_BIT];
            upd_q <= upd_q & ~pwdata[`T3_UPD_BIT];
            reload_q <= reload_q & ~pwdata[`T3_RELOAD_BIT];
         end
      end
   end

   // zero-reached flag; a zero hit in the clearing cycle wins
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         irq_flag_q <= 1'b0;
      else if (ce)
      begin
         if (zero_hit)
            irq_flag_q <= 1'b1;
         else if (wr_ctrl & ~pwdata[`T3_IRQ_BIT])
            irq_flag_q <= 1'b0;
         else if (wr_clr & pwdata[`T3_IRQ_BIT])
            irq_flag_q <= 1'b0;
      end
   end

   // fixed count and running count; a software load beats a tick in the same cycle
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fixed_q <= `T3_CNT_ZERO;
         count_q <= `T3_CNT_ZERO;
      end
      else if (ce)
      begin
         if (wr_fixed)
            fixed_q <= pwdata[`T3_CNT_W-1:0];
         if (wr_fixed & upd_q)
            count_q <= pwdata[`T3_CNT_W-1:0];
         else if (!duty_q)
         begin
            if (count_q == `T3_CNT_ZERO)
            begin
               // keeps loading so a non-zero fixed count starts the timer at once
               if (reload_q)
                  count_q <= fixed_q;
            end
            else if (tick)
            begin
               if (zero_hit)
                  count_q <= reload_q ? fixed_q : `T3_CNT_ZERO;
               else
                  count_q <= cnt_dec;
            end
         end
      end
   end

   // duty measurement: count high and low cycles between detected edges
   // the first edge after arming only starts a period, so a write costs one full period
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         prev_q <= 1'b0;
         armed_q <= 1'b0;
         hi_cnt_q <= `T3_CNT_ZERO;
         lo_cnt_q <= `T3_CNT_ZERO;
         res_hi_q <= `T3_CNT_ZERO;
         res_lo_q <= `T3_CNT_ZERO;
         valid_q <= 1'b0;
      end
      else if (ce)
      begin
         // a new select or polarity can flip the level at once; masking one cycle
         // keeps that flip from passing for an edge, at the cost of a real edge there
         if (wr_ctrl | wr_clr)
            prev_q <= 1'b1;
         else
            prev_q <= level;
         if (!duty_q | wr_ctrl | wr_clr)
         begin
            valid_q <= 1'b0;
            armed_q <= 1'b0;
            hi_cnt_q <= `T3_CNT_ZERO;
            lo_cnt_q <= `T3_CNT_ZERO;
         end
         else if (edge_det)
         begin
            armed_q <= 1'b1;
            if (armed_q)
            begin
               res_hi_q <= hi_cnt_q;
               res_lo_q <= lo_cnt_q;
               valid_q <= 1'b1;
            end
            hi_cnt_q <= `T3_CNT_ONE;
            lo_cnt_q <= `T3_CNT_ZERO;
         end
         else if (armed_q)
         begin
            // counters saturate rather than wrap on very slow inputs
            if (level & (hi_cnt_q != {`T3_CNT_W{1'b1}}))
               hi_cnt_q <= hi_cnt_q + `T3_CNT_ONE;
            else if (!level & (lo_cnt_q != {`T3_CNT_W{1'b1}}))
               lo_cnt_q <= lo_cnt_q + `T3_CNT_ONE;
         end
      end
   end
endmodule

// ---- verification/timer3_ctrl_asserts.sv ----
`timescale 1ns/100ps
module timer3_ctrl_asserts
(
   input wire core_clk,
   input wire nrst,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire timer_irq
);
   // bus phases aimed at the control word, and the unmapped-address decode
   wire [11:0] a = paddr[11:0];
   wire wr_c = psel && penable && pwrite && ce && a == 12'h000;
   wire rd_c = psel && penable && !pwrite && a == 12'h000;
   wire su_c = psel && !penable && !pwrite && ce && a == 12'h000;
   wire bad_a = a != 12'h000 && a != 12'h008 && a != 12'h010 && a != 12'h020;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   property p_rsvd; rd_c |-> prdata[31:20] == 12'h000 && prdata[13:11] == 3'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_vld; rd_c && prdata[10] |-> prdata[9]; endproperty
   a_vld: assert property (p_vld) else $error("valid outside duty");
   // valid cannot come back within two cycles of a control write
   property p_vwr; wr_c ##[1:2] su_c |=> !prdata[10]; endproperty
   a_vwr: assert property (p_vwr) else $error("valid kept over write");
   property p_ien; wr_c && !pwdata[14] |=> !timer_irq; endproperty
   a_ien: assert property (p_ien) else $error("irq while disabled");
   property p_idu; wr_c && pwdata[9] |=> !timer_irq; endproperty
   a_idu: assert property (p_idu) else $error("irq in duty mode");
   property p_rb;
      wr_c ##2 su_c ##1 rd_c |-> prdata[19:16] == $past(pwdata[19:16], 3)
         && prdata[9:6] == $past(pwdata[9:6], 3) && prdata[14] == $past(pwdata[14], 3);
   endproperty
   a_rb: assert property (p_rb) else $error("control readback");
   property p_err;
      psel && penable && bad_a |-> pslverr && (pwrite || prdata == 32'h0000_0000);
   endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_ok; psel && penable && !bad_a |-> pready && !pslverr; endproperty
   a_ok: assert property (p_ok) else $error("mapped access refused");
   c_irq: cover property (timer_irq);
   c_vld: cover property (rd_c && prdata[10]);
   c_err: cover property (pslverr);
endmodule
bind timer3_ctrl timer3_ctrl_asserts u_chk (.core_clk(core_clk), .nrst(nrst), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_irq(timer_irq));

// ---- verification/timer3_duty_measure_control_tb_top.sv ----
`timescale 1ns/100ps
module timer3_duty_measure_control_tb_top;
   reg core_clk = 1'b0;
   reg nrst = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [31:0] paddr = 32'h0000_0000;
   reg [31:0] pwdata = 32'h0000_0000;
   reg wave_on = 1'b0;
   reg wave = 1'b0;
   reg [31:0] r;
   reg e;
   reg [63:0] rows [0:9];
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire timer_irq;
   integer bad_count = 0;
   integer n_checks = 0;
   integer cyc = 0;
   integer i;
   // every source pin follows one wave so each pin select code (1 to 8) sees edges
   timer3_ctrl i_dut (.core_clk(core_clk), .nrst(nrst), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pulse_in({5{wave}}), .quadrature_input_a(wave),
      .quadrature_input_b(wave), .xtal_32k(wave), .timer_irq(timer_irq));
   always #25 core_clk = ~core_clk;
   // wave: 6 high, 10 low, period 16; also the hang limit
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      wave <= wave_on && (cyc % 16) < 6;
      if (cyc == 6000)
      begin
         bad_count = bad_count + 1;
         tally_and_finish;
      end
   end
   task chk(input string nm, input [31:0] exp, input [31:0] got);
   begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   end
   endtask
   // one apb transfer; request held until pready is seen high
   task xfer(input w, input [11:0] a, input [31:0] d);
   begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {20'h0_0000, a};
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   task tally_and_finish;
   begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   initial
   begin
      // written word beside the word read back; flag writes of 1 keep a clear flag clear
      rows[0] = {32'h0001_8040, 32'h0001_0040};
      rows[1] = {32'h0002_0080, 32'h0002_0080};
      rows[2] = {32'h0003_0100, 32'h0003_0100};
      rows[3] = {32'h0004_4000, 32'h0004_4000};
      rows[4] = {32'h0005_00C0, 32'h0005_00C0};
      rows[5] = {32'h0006_01C0, 32'h0006_01C0};
      rows[6] = {32'h0007_4040, 32'h0007_4040};
      rows[7] = {32'h0008_8000, 32'h0008_0000};
      rows[8] = {32'h000C_0000, 32'h000C_0000};
      rows[9] = {32'h0000_0000, 32'h0000_0000};
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      xfer(0, 12'h000, 0);
      chk("ctrl reset", 32'h0000_0000, r);
      for (i = 0; i < 10; i = i + 1)
      begin
         xfer(1, 12'h000, rows[i][63:32]);
         xfer(0, 12'h000, 0);
         chk("ctrl row", rows[i][31:0], r);
      end
      // never-tick source holds a count loaded through update
      xfer(1, 12'h000, 32'h0000_4080);
      xfer(1, 12'h020, 32'h0000_0005);
      repeat (5) @(posedge core_clk);
      xfer(0, 12'h010, 0);
      chk("count held", 32'h0000_0005, r);
      xfer(1, 12'h000, 32'h000C_4080);
      repeat (10) @(posedge core_clk);
      chk("irq", 1, timer_irq);
      xfer(0, 12'h010, 0);
      chk("count frozen", 0, r);
      xfer(1, 12'h000, 32'h0000_C280);
      xfer(1, 12'h000, 32'h0000_4000);
      @(posedge core_clk);
      chk("irq cleared", 0, timer_irq);
      // reload from a zero fixed count, then a live fixed value
      xfer(1, 12'h020, 32'h0000_0000);
      xfer(1, 12'h000, 32'h0000_0040);
      xfer(1, 12'h020, 32'h0000_0003);
      xfer(0, 12'h010, 0);
      chk("count reload", 32'h0000_0003, r);
      xfer(1, 12'h000, 32'h000C_0040);
      repeat (10) @(posedge core_clk);
      xfer(0, 12'h010, 0);
      chk("count live", 1, r[15:0] != 16'h0000 && r[15:0] <= 16'h0003);
      xfer(1, 12'h000, 32'h0000_8040);
      xfer(0, 12'h000, 0);
      chk("flag", 32'h0000_8000, r & 32'h0000_8000);
      xfer(1, 12'h008, 32'h0000_8000);
      xfer(0, 12'h000, 0);
      chk("alias clear", 32'h0000_0040, r);
      xfer(0, 12'h004, 0);
      chk("unmapped err", 32'h0000_0001, {31'h0000_0000, e});
      chk("unmapped data", 32'h0000_0000, r);
      // duty measurement on each pin source, polarity alternating
      wave_on <= 1'b1;
      for (i = 1; i < 9; i = i + 1)
      begin
         xfer(1, 12'h000, {12'h000, i[3:0], 7'h01, i[0], 8'h00});
         xfer(0, 12'h000, 0);
         chk("valid early", 0, r & 32'h0000_0400);
         repeat (60) @(posedge core_clk);
         xfer(0, 12'h000, 0);
         chk("valid", 32'h0000_0400, r & 32'h0000_0400);
         xfer(0, 12'h010, 0);
         chk("period", 32'h0000_0010, r[31:16] + r[15:0]);
         // inverted input counts the low part of the wave as high time
         chk("high time", i[0] ? 32'h0000_000A : 32'h0000_0006, {16'h0000, r[15:0]});
      end
      xfer(1, 12'h000, 0);
      xfer(0, 12'h000, 0);
      chk("valid off", 0, r & 32'h0000_0400);
      // reset again in mid-run; every field must come back cleared
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      xfer(0, 12'h000, 0);
      chk("ctrl after reset", 32'h0000_0000, r);
      chk("irq after reset", 32'h0000_0000, {31'h0000_0000, timer_irq});
      tally_and_finish;
   end
endmodule
